// ---- ftm_pkg.sv ----
// Shared constants for the fan tach and chassis intrusion monitor
package ftm_pkg;

	// ----------------------------------------------------------------
	// Clock and oscillator timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned OSC_HZ          = 22_500;
	// Longest period that still fits: round down
	localparam int unsigned OSC_DIV_CYCLES  = CLK_HZ / OSC_HZ;

	// Intrusion release pulse, a least time: round up
	localparam int unsigned CI_PULSE_MS     = 20;
	localparam int unsigned CI_PULSE_CYCLES = (CLK_HZ / 1000 * CI_PULSE_MS) + ((CLK_HZ % 1000) != 0 ? 1 : 0);

	// ----------------------------------------------------------------
	// Counter and prescaler
	// ----------------------------------------------------------------
	localparam int unsigned NUM_FANS        = 2;
	localparam logic [7:0]  COUNT_FULL      = 8'hFF;
	localparam logic [7:0]  COUNT_ZERO      = 8'h00;
	localparam logic [1:0]  DIV_RESET_CODE  = 2'h1;
	localparam logic [1:0]  TACH_EDGES_END  = 2'h2;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int unsigned STAT_FAN_A      = 0;
	localparam int unsigned STAT_FAN_B      = 1;
	localparam int unsigned STAT_INTRUSION  = 2;
	localparam int unsigned STAT_W          = 3;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PICK,
		ST_ARM,
		ST_COUNT,
		ST_STORE
	} ftm_state_t;

endpackage : ftm_pkg

// ---- ftm_tick_gen.sv ----
// Oscillator tick generator with 1/2/4/8 prescaler ahead of the fan counter
`timescale 1ns/1ps
`default_nettype none

module ftm_tick_gen #(
	parameter int unsigned OSC_DIV = ftm_pkg::OSC_DIV_CYCLES,
	parameter int unsigned BASE_W  = 11
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       restart,
	input  wire logic [1:0] div_code,
	output logic            tick_ff
);

	initial
	begin
		if (OSC_DIV < 2 || OSC_DIV > (2 ** BASE_W))
			$error("ftm_tick_gen: OSC_DIV does not fit BASE_W");
	end

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	// Code n divides by 2**n
	function automatic logic [2:0] div_last(input logic [1:0] code);
		case (code)
			2'h0:    div_last = 3'h0;
			2'h1:    div_last = 3'h1;
			2'h2:    div_last = 3'h3;
			default: div_last = 3'h7;
		endcase
	endfunction : div_last

	localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(OSC_DIV - 1);

	logic [BASE_W-1:0] base_cnt_ff;
	logic [2:0]        pre_cnt_ff;
	logic              base_tick;

	assign base_tick = (base_cnt_ff == BASE_LAST);

	// ----------------------------------------------------------------
	// Base 22.5 kHz oscillator
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			base_cnt_ff <= '0;
		else if (restart || base_tick)
			base_cnt_ff <= '0;
		else
			base_cnt_ff <= base_cnt_ff + 1'b1;
	end

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pre_cnt_ff <= 3'h0;
			tick_ff    <= 1'b0;
		end
		else if (restart)
		begin
			pre_cnt_ff <= 3'h0;
			tick_ff    <= 1'b0;
		end
		else if (base_tick)
		begin
			pre_cnt_ff <= (pre_cnt_ff >= div_last(div_code)) ? 3'h0 : pre_cnt_ff + 3'h1;
			tick_ff    <= (pre_cnt_ff >= div_last(div_code));
		end
		else
			tick_ff    <= 1'b0;
	end

endmodule : ftm_tick_gen

`default_nettype wire

// ---- ftm_fan_intrusion_monitor.sv ----
// Fan period measurement, limit status, interrupt pin and chassis intrusion
//
// Functional notes
// [RULE1] Measure fan period: gate 22.5 kHz into 8-bit counter over two tach periods.
// [RULE2] Monitoring starts on start bit one with interrupt-clear bit zero.
// [RULE3] Measurement starts on tach rising edge, ends on second following rising edge.
// [RULE4] Fans measured in turn; end at two tach cycles or count 255.
// [RULE5] Completed counts stored per fan, readable anytime, refreshed while monitoring.
// [RULE6] Prescaler divides by 1, 2, 4 or 8; reset default is 2.
// [RULE7] Count equals 22500*60 over rpm times divisor.
// [RULE8] Fan divisor selections live in bits 4 to 7 of the divisor register.
// [RULE9] Bits 5:4 fan A, 7:6 fan B; codes 0..3 mean 1,2,4,8.
// [RULE10] Only low-speed limit; failure when count exceeds limit.
// [RULE11] Software waits three slowest tach periods per fan before trusting values.
// [RULE12] Fan and analog monitoring start together, otherwise unsynchronised.
// [RULE13] High intrusion level raises status once powered and monitoring.
// [RULE14] Intrusion status persists while latch holds line high.
// [RULE15] Clear bit drives intrusion line low open-drain 20 ms, then self-clears.
// [RULE16] External latch resets when its line is pulled low.
// [RULE17] New measurement compared; status bit one if out of limit, else zero.
// [RULE18] Mask bit one hides its status bit, zero lets it assert.
// [RULE19] Unmasked status bits ORed to pull active-low interrupt pin low.
// [RULE20] Interrupt pin driven only with enable high and clear low.
// [RULE21] Status read returns contents then clears until next update.
// [RULE22] Interrupt-clear bit releases pin without touching status contents.
// [RULE23] Channel mode bits 0,1 select tach or analog; zero means tach.
`timescale 1ns/1ps
`default_nettype none

module ftm_fan_intrusion_monitor #(
	parameter int unsigned CI_PULSE_CYCLES = ftm_pkg::CI_PULSE_CYCLES,
	parameter int unsigned CI_CNT_W        = 20
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Configuration register bits
	input  wire logic       cfg_start,
	input  wire logic       cfg_int_enable,
	input  wire logic       cfg_int_clear,
	// Divisor register bits 7:4
	input  wire logic [3:0] fan_div_sel,
	// Channel mode bits 1:0, one means analog
	input  wire logic [1:0] chan_mode,
	input  wire logic [7:0] fan_limit_a,
	input  wire logic [7:0] fan_limit_b,
	input  wire logic [2:0] int_mask,
	input  wire logic       status_read,
	input  wire logic       intrusion_clear_wr,
	// Fan, intrusion and interrupt pins
	input  wire logic       tach_input_a,
	input  wire logic       tach_input_b,
	input  wire logic       intrusion_line_in,
	output logic            intrusion_line_out_ff,
	output logic            intrusion_line_oe_ff,
	output logic            int_n_out_ff,
	output logic            int_n_oe_ff,
	// Readback
	output logic [7:0]      fan_value_a_ff,
	output logic [7:0]      fan_value_b_ff,
	output logic [2:0]      status_ff,
	output logic            intrusion_clear_bit_ff,
	output logic            fan_div_reg_ff,
	output logic            analog_start_ff
);

	initial
	begin
		if (CI_PULSE_CYCLES < 1 || CI_PULSE_CYCLES >= (2 ** CI_CNT_W))
			$error("ftm_fan_intrusion_monitor: CI_PULSE_CYCLES does not fit CI_CNT_W");
	end

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic fan_is_tach(input logic [1:0] mode, input logic idx);
		fan_is_tach = !mode[idx];
	endfunction : fan_is_tach

	function automatic logic [1:0] fan_div_code(input logic [3:0] sel, input logic idx);
		fan_div_code = idx ? sel[3:2] : sel[1:0];
	endfunction : fan_div_code

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] tach_meta_ff;
	logic [1:0] tach_sync_ff;
	logic [1:0] tach_prev_ff;
	logic [1:0] tach_rise;
	logic [1:0] tach_raw;
	logic       ci_meta_ff;
	logic       ci_sync_ff;

	assign tach_raw = {tach_input_b, tach_input_a};

	genvar gi;
	generate
		for (gi = 0; gi < ftm_pkg::NUM_FANS; gi++)
		begin : g_tach_sync
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					tach_meta_ff[gi] <= 1'b0;
					tach_sync_ff[gi] <= 1'b0;
					tach_prev_ff[gi] <= 1'b0;
				end
				else
				begin
					tach_meta_ff[gi] <= tach_raw[gi];
					tach_sync_ff[gi] <= tach_meta_ff[gi];
					tach_prev_ff[gi] <= tach_sync_ff[gi];
				end
			end
			assign tach_rise[gi] = tach_sync_ff[gi] && !tach_prev_ff[gi];
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ci_meta_ff <= 1'b0;
			ci_sync_ff <= 1'b0;
		end
		else
		begin
			ci_meta_ff <= intrusion_line_in;
			ci_sync_ff <= ci_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	logic run_ff;
	logic nxt_run;

	// Clear bit only gates the start; raising it later does not stop the fans
	always_comb
	begin
		nxt_run = run_ff;
		if (!cfg_start)
			nxt_run = 1'b0;
		else if (!cfg_int_clear)
			nxt_run = 1'b1;                                   // [RULE2]
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			run_ff          <= 1'b0;
			analog_start_ff <= 1'b0;
		end
		else
		begin
			run_ff          <= nxt_run;
			analog_start_ff <= nxt_run && !run_ff;            // [RULE12]
		end
	end

	// ----------------------------------------------------------------
	// Measurement sequencer
	// ----------------------------------------------------------------
	ftm_pkg::ftm_state_t state_ff;
	ftm_pkg::ftm_state_t nxt_state;
	logic                fan_sel_ff;
	logic                nxt_fan_sel;
	logic [7:0]          count_ff;
	logic [7:0]          nxt_count;
	logic [1:0]          edges_ff;
	logic [1:0]          nxt_edges;
	logic                presc_restart;
	logic                osc_tick;
	logic                store;
	logic                cur_rise;
	logic [7:0]          cur_limit;

	assign cur_rise  = tach_rise[fan_sel_ff];
	assign cur_limit = fan_sel_ff ? fan_limit_b : fan_limit_a;
	assign store     = (state_ff == ftm_pkg::ST_STORE);

	ftm_tick_gen #(
		.OSC_DIV (ftm_pkg::OSC_DIV_CYCLES),
		.BASE_W  (11)
	) u_tick (
		.clk      (clk),
		.reset_n  (reset_n),
		.restart  (presc_restart),
		.div_code (fan_div_code(fan_div_sel, fan_sel_ff)),   // [RULE8] [RULE9]
		.tick_ff  (osc_tick)
	);

	always_comb
	begin
		nxt_state     = state_ff;
		nxt_fan_sel   = fan_sel_ff;
		nxt_count     = count_ff;
		nxt_edges     = edges_ff;
		presc_restart = 1'b0;
		case (state_ff)
			ftm_pkg::ST_IDLE:
			begin
				if (run_ff)
					nxt_state = ftm_pkg::ST_PICK;
			end
			ftm_pkg::ST_PICK:
			begin
				nxt_count     = ftm_pkg::COUNT_ZERO;
				nxt_edges     = 2'h0;
				presc_restart = 1'b1;
				// Analog-configured pins are skipped
				if (fan_is_tach(chan_mode, fan_sel_ff))       // [RULE23]
					nxt_state = ftm_pkg::ST_ARM;
				else if (fan_is_tach(chan_mode, !fan_sel_ff))
					nxt_fan_sel = !fan_sel_ff;
			end
			ftm_pkg::ST_ARM:
			begin
				// A stalled fan still ends at full scale
				if (cur_rise)
				begin
					nxt_count     = ftm_pkg::COUNT_ZERO;      // [RULE3]
					presc_restart = 1'b1;
					nxt_state     = ftm_pkg::ST_COUNT;
				end
				else if (osc_tick)
				begin
					nxt_count = count_ff + 8'h01;
					if (count_ff == ftm_pkg::COUNT_FULL - 8'h01)
						nxt_state = ftm_pkg::ST_STORE;        // [RULE4]
				end
			end
			ftm_pkg::ST_COUNT:
			begin
				if (osc_tick && count_ff != ftm_pkg::COUNT_FULL)
					nxt_count = count_ff + 8'h01;             // [RULE1] [RULE7]
				if (cur_rise)
					nxt_edges = edges_ff + 2'h1;
				if (cur_rise && edges_ff == ftm_pkg::TACH_EDGES_END - 2'h1)
					nxt_state = ftm_pkg::ST_STORE;            // [RULE3]
				else if (nxt_count == ftm_pkg::COUNT_FULL)
					nxt_state = ftm_pkg::ST_STORE;            // [RULE4]
			end
			ftm_pkg::ST_STORE:
			begin
				nxt_fan_sel = !fan_sel_ff;                    // [RULE4]
				nxt_state   = ftm_pkg::ST_PICK;
			end
			default:
				nxt_state = ftm_pkg::ST_IDLE;
		endcase
		if (!run_ff)
			nxt_state = ftm_pkg::ST_IDLE;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_ff   <= ftm_pkg::ST_IDLE;
			fan_sel_ff <= 1'b0;
			count_ff   <= ftm_pkg::COUNT_ZERO;
			edges_ff   <= 2'h0;
		end
		else
		begin
			state_ff   <= nxt_state;
			fan_sel_ff <= nxt_fan_sel;
			count_ff   <= nxt_count;
			edges_ff   <= nxt_edges;
		end
	end

	// ----------------------------------------------------------------
	// Value registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fan_value_a_ff <= ftm_pkg::COUNT_ZERO;
			fan_value_b_ff <= ftm_pkg::COUNT_ZERO;
		end
		else if (store && !fan_sel_ff)
			fan_value_a_ff <= count_ff;                       // [RULE5]
		else if (store && fan_sel_ff)
			fan_value_b_ff <= count_ff;                       // [RULE5]
	end

	// Divisor field readback marks whether the reset default is still held
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			fan_div_reg_ff <= 1'b1;
		else
			fan_div_reg_ff <= (fan_div_sel[1:0] == ftm_pkg::DIV_RESET_CODE)
				&& (fan_div_sel[3:2] == ftm_pkg::DIV_RESET_CODE);  // [RULE6]
	end

	// ----------------------------------------------------------------
	// Status register
	// ----------------------------------------------------------------
	logic [2:0] nxt_status;
	logic       fail;

	// Period grows as speed drops, so failure is count above limit
	assign fail = (count_ff > cur_limit);                     // [RULE10]

	always_comb
	begin
		nxt_status = status_ff;
		if (status_read)
			nxt_status = 3'h0;                                // [RULE21]
		// Updates come after the read clear so a same-cycle update wins
		if (store)
			nxt_status[fan_sel_ff ? ftm_pkg::STAT_FAN_B : ftm_pkg::STAT_FAN_A] = fail;  // [RULE17]
		if (run_ff && ci_sync_ff && !intrusion_line_oe_ff)
			nxt_status[ftm_pkg::STAT_INTRUSION] = 1'b1;       // [RULE13] [RULE14]
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			status_ff <= 3'h0;
		else
			status_ff <= nxt_status;
	end

	// ----------------------------------------------------------------
	// Interrupt pin
	// ----------------------------------------------------------------
	logic int_drive;

	// Clear bit only gates the pin; status stays intact
	assign int_drive = cfg_int_enable && !cfg_int_clear       // [RULE20] [RULE22]
		&& |(status_ff & ~int_mask);                          // [RULE18] [RULE19]

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			int_n_out_ff <= 1'b1;
			int_n_oe_ff  <= 1'b0;
		end
		else
		begin
			int_n_out_ff <= !int_drive;
			int_n_oe_ff  <= int_drive;
		end
	end

	// ----------------------------------------------------------------
	// Intrusion latch release pulse
	// ----------------------------------------------------------------
	localparam logic [CI_CNT_W-1:0] CI_LAST = CI_CNT_W'(CI_PULSE_CYCLES - 1);

	logic [CI_CNT_W-1:0] ci_cnt_ff;

	// Pulling low resets the external latch
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			intrusion_clear_bit_ff <= 1'b0;
			intrusion_line_oe_ff   <= 1'b0;
			intrusion_line_out_ff  <= 1'b0;
			ci_cnt_ff              <= '0;
		end
		else if (!intrusion_clear_bit_ff)
		begin
			if (intrusion_clear_wr)
			begin
				intrusion_clear_bit_ff <= 1'b1;                // [RULE15]
				intrusion_line_oe_ff   <= 1'b1;                // [RULE16]
				ci_cnt_ff              <= '0;
			end
		end
		else if (ci_cnt_ff == CI_LAST)
		begin
			intrusion_clear_bit_ff <= 1'b0;                    // [RULE15]
			intrusion_line_oe_ff   <= 1'b0;
		end
		else
			ci_cnt_ff <= ci_cnt_ff + 1'b1;
	end

endmodule : ftm_fan_intrusion_monitor

`default_nettype wire

// ---- ftm_fan_partner.sv ----
// Behavioural fans and chassis intrusion latch on the pin side
`timescale 1ns/1ps
`default_nettype none

module ftm_fan_partner #(
	parameter int unsigned HALF_A_NS = 80000,
	parameter int unsigned HALF_B_NS = 60000
) (
	input  wire logic intr_event,
	input  wire logic line_out,
	input  wire logic line_oe,
	output logic      tach_a,
	output logic      tach_b,
	output wire logic line_level
);
	logic latch_ff;
	wire logic pulled_low = line_oe && !line_out;

	// Half periods land on falling clock edges, away from the sampling edge
	initial
	begin
		tach_a = 1'b0;
		tach_b = 1'b0;
		latch_ff = 1'b0;
	end
	always #(HALF_A_NS) tach_a = ~tach_a;
	always #(HALF_B_NS) tach_b = ~tach_b;

	// Pull-low dominates a new event, as in a real reset-priority latch
	always @(posedge intr_event or posedge pulled_low)
		latch_ff <= !pulled_low;
	assign line_level = latch_ff && !pulled_low;
endmodule : ftm_fan_partner

`default_nettype wire

// ---- ftm_fan_intrusion_monitor_asserts.sv ----
// Port-level assertions for the fan and intrusion monitor
`timescale 1ns/1ps
`default_nettype none

module ftm_monitor_chk #(
	parameter int unsigned CI_PULSE_CYCLES = 20
) (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       cfg_start,
	input wire logic       cfg_int_enable,
	input wire logic       cfg_int_clear,
	input wire logic [3:0] fan_div_sel,
	input wire logic [2:0] int_mask,
	input wire logic       intrusion_clear_wr,
	input wire logic       intrusion_line_in,
	input wire logic       intrusion_line_out_ff,
	input wire logic       intrusion_line_oe_ff,
	input wire logic       int_n_out_ff,
	input wire logic       int_n_oe_ff,
	input wire logic [2:0] status_ff,
	input wire logic       intrusion_clear_bit_ff,
	input wire logic       fan_div_reg_ff,
	input wire logic       analog_start_ff
);
	// ----------------------------------------------------------------
	// Release pulse length counter
	// ----------------------------------------------------------------
	int unsigned rel_cnt_ff;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rel_cnt_ff <= 0;
		else
			rel_cnt_ff <= intrusion_line_oe_ff ? rel_cnt_ff + 1 : 0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Sync flops need a few cycles of steady level
	sequence s_intr_armed;
		(cfg_start && !cfg_int_clear && intrusion_line_in && !intrusion_line_oe_ff && !intrusion_clear_bit_ff) [*4];
	endsequence
	sequence s_release;
		intrusion_line_oe_ff && intrusion_clear_bit_ff && !intrusion_line_out_ff;
	endsequence

	start_pulse_a: assert property (analog_start_ff |=> !analog_start_ff)
		else $error("start pulse wider than one cycle");
	start_cause_a: assert property ($rose(analog_start_ff) |-> $past(cfg_start) && !$past(cfg_int_clear))
		else $error("start pulse without start request");
	pin_off_a: assert property (!cfg_int_enable || cfg_int_clear |=> !int_n_oe_ff)
		else $error("interrupt pin driven while disabled");
	pin_drive_a: assert property (cfg_int_enable && !cfg_int_clear && |(status_ff & ~int_mask) |=> int_n_oe_ff)
		else $error("interrupt pin not driven");
	mask_hide_a: assert property ((status_ff & ~int_mask) == 3'h0 |=> !int_n_oe_ff)
		else $error("masked status drove interrupt pin");
	pin_low_a: assert property (int_n_oe_ff |-> !int_n_out_ff)
		else $error("interrupt pin driven high");
	release_start_a: assert property (intrusion_clear_wr && !intrusion_clear_bit_ff |=> s_release)
		else $error("release pulse did not start");
	release_len_a: assert property ($fell(intrusion_line_oe_ff) |-> rel_cnt_ff == CI_PULSE_CYCLES)
		else $error("release pulse length wrong");
	release_cause_a: assert property ($rose(intrusion_line_oe_ff) |-> $past(intrusion_clear_wr))
		else $error("release pulse without write");
	intr_keep_a: assert property (status_ff[2] && intrusion_line_in && !intrusion_line_oe_ff |=> status_ff[2])
		else $error("intrusion status dropped while line high");
	intr_raise_a: assert property (s_intr_armed |=> status_ff[2])
		else $error("intrusion level not recorded");
	div_flag_a: assert property (1'b1 |=> fan_div_reg_ff == ($past(fan_div_sel) == 4'h5))
		else $error("divisor default flag wrong");
endmodule : ftm_monitor_chk

bind ftm_fan_intrusion_monitor ftm_monitor_chk #(.CI_PULSE_CYCLES(CI_PULSE_CYCLES)) u_chk (
	.clk(clk), .reset_n(reset_n), .cfg_start(cfg_start), .cfg_int_enable(cfg_int_enable),
	.cfg_int_clear(cfg_int_clear), .fan_div_sel(fan_div_sel), .int_mask(int_mask),
	.intrusion_clear_wr(intrusion_clear_wr), .intrusion_line_in(intrusion_line_in),
	.intrusion_line_out_ff(intrusion_line_out_ff), .intrusion_line_oe_ff(intrusion_line_oe_ff),
	.int_n_out_ff(int_n_out_ff), .int_n_oe_ff(int_n_oe_ff), .status_ff(status_ff),
	.intrusion_clear_bit_ff(intrusion_clear_bit_ff), .fan_div_reg_ff(fan_div_reg_ff),
	.analog_start_ff(analog_start_ff));

`default_nettype wire

// ---- ftm_fan_intrusion_monitor_tb_top.sv ----
// Self-checking bench for the fan and intrusion monitor
`timescale 1ns/1ps
`default_nettype none

module ftm_fan_intrusion_monitor_tb_top;
	localparam int unsigned CI_CYC = 20;
	logic       clk = 1'b0;
	logic       reset_n;
	logic       cfg_start;
	logic       cfg_int_enable;
	logic       cfg_int_clear;
	logic [3:0] fan_div_sel;
	logic [2:0] int_mask;
	logic       status_read;
	logic       clr_wr;
	logic       intr_event;
	logic       tach_a;
	logic       tach_b;
	wire logic  line_level;
	logic       line_out;
	logic       line_oe;
	logic       int_n_out;
	logic       int_n_oe;
	logic       clr_bit;
	logic       div_flag;
	logic [7:0] val_a;
	logic [7:0] val_b;
	logic [2:0] status;
	logic [1:0] chan_mode;
	logic [7:0] lim_a;
	logic [7:0] lim_b;
	logic       astart;
	int         miscompares;
	int         checks;
	int         cyc = 0;

	ftm_fan_intrusion_monitor #(.CI_PULSE_CYCLES(CI_CYC), .CI_CNT_W(20)) uut (
		.clk(clk), .reset_n(reset_n), .cfg_start(cfg_start), .cfg_int_enable(cfg_int_enable),
		.cfg_int_clear(cfg_int_clear), .fan_div_sel(fan_div_sel), .chan_mode(chan_mode),
		.fan_limit_a(lim_a), .fan_limit_b(lim_b), .int_mask(int_mask), .status_read(status_read),
		.intrusion_clear_wr(clr_wr), .tach_input_a(tach_a), .tach_input_b(tach_b),
		.intrusion_line_in(line_level), .intrusion_line_out_ff(line_out), .intrusion_line_oe_ff(line_oe),
		.int_n_out_ff(int_n_out), .int_n_oe_ff(int_n_oe), .fan_value_a_ff(val_a), .fan_value_b_ff(val_b),
		.status_ff(status), .intrusion_clear_bit_ff(clr_bit), .fan_div_reg_ff(div_flag),
		.analog_start_ff(astart));

	// Fan A period 4000 clocks, fan B 3000 clocks
	ftm_fan_partner #(.HALF_A_NS(80000), .HALF_B_NS(60000)) u_fans (
		.intr_event(intr_event), .line_out(line_out), .line_oe(line_oe),
		.tach_a(tach_a), .tach_b(tach_b), .line_level(line_level));

	always #20 clk = ~clk;

	task automatic final_report();
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic read_status();
		@(posedge clk) status_read <= 1'b1;
		@(posedge clk) status_read <= 1'b0;
		#1;
	endtask : read_status

	// Count is two tach periods over 1111 clocks times the divisor per tick, within one tick
	task automatic wait_range(input bit fan_b, input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] v;
		repeat (45000)
		begin
			tick(1);
			v = fan_b ? val_b : val_a;
			if (v >= lo && v <= hi)
				break;
		end
		check(8'(v >= lo && v <= hi), 8'h01);
	endtask : wait_range

	task automatic t_reset();
		tick(1);
		check(8'(status), 8'h00);
		check(8'(int_n_oe), 8'h00);
		check(8'(div_flag), 8'h01);
	endtask : t_reset

	task automatic t_measure();
		@(posedge clk);
		fan_div_sel <= 4'h0;
		cfg_int_enable <= 1'b1;
		cfg_start <= 1'b1;
		tick(1);
		check(8'(astart), 8'h01);
		tick(1);
		check(8'(astart), 8'h00);
		wait_range(1'b0, 8'h07, 8'h08);
		wait_range(1'b1, 8'h05, 8'h06);
		check(8'(status), 8'h01);
	endtask : t_measure

	task automatic t_int_pin();
		tick(2);
		check(8'(int_n_oe), 8'h01);
		check(8'(int_n_out), 8'h00);
		@(posedge clk) int_mask <= 3'h1;
		tick(2);
		check(8'(int_n_oe), 8'h00);
		@(posedge clk);
		int_mask <= 3'h0;
		cfg_int_clear <= 1'b1;
		tick(2);
		check(8'(int_n_oe), 8'h00);
		check(8'(status), 8'h01);
		read_status();
		check(8'(status), 8'h00);
	endtask : t_int_pin

	task automatic t_divisor();
		@(posedge clk) fan_div_sel <= 4'h5;
		wait_range(1'b0, 8'h03, 8'h04);
		check(8'(div_flag), 8'h01);
		check(8'(status[0]), 8'h00);
	endtask : t_divisor

	task automatic t_intrusion();
		@(posedge clk);
		cfg_int_clear <= 1'b0;
		int_mask <= 3'h3;
		intr_event <= 1'b1;
		tick(6);
		check(8'(status[2]), 8'h01);
		check(8'(int_n_oe), 8'h01);
		read_status();
		check(8'(status[2]), 8'h01);
		@(posedge clk);
		intr_event <= 1'b0;
		clr_wr <= 1'b1;
		@(posedge clk) clr_wr <= 1'b0;
		#1;
		check(8'(clr_bit), 8'h01);
		check(8'(line_level), 8'h00);
		tick(CI_CYC + 3);
		check(8'(clr_bit), 8'h00);
		check(8'(line_level), 8'h00);
		read_status();
		check(8'(status[2]), 8'h00);
	endtask : t_intrusion

	// Fan B as analog is never picked; a B store would flag against limit zero
	task automatic t_skip();
		@(posedge clk);
		chan_mode <= 2'h2;
		lim_a <= 8'h02;
		lim_b <= 8'h00;
		repeat (2)
		begin
			read_status();
			repeat (30000)
			begin
				if (status[0])
					break;
				tick(1);
			end
			check(8'(status[0]), 8'h01);
		end
		check(8'(status[1]), 8'h00);
	endtask : t_skip

	// Worst case run is about 58000 cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 95000)
		begin
			miscompares++;
			final_report();
		end
	end

	initial
	begin
		reset_n = 1'b0;
		cfg_start = 1'b0;
		cfg_int_enable = 1'b0;
		cfg_int_clear = 1'b0;
		fan_div_sel = 4'h5;
		int_mask = 3'h0;
		status_read = 1'b0;
		clr_wr = 1'b0;
		intr_event = 1'b0;
		chan_mode = 2'h0;
		lim_a = 8'h06;
		lim_b = 8'h06;
		miscompares = 0;
		checks = 0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_measure();
		t_int_pin();
		t_divisor();
		t_intrusion();
		t_skip();
		final_report();
	end
endmodule : ftm_fan_intrusion_monitor_tb_top

`default_nettype wire
